// >>> inc/iira_pkg.sv
// Constants for the indirect register access block of the I/O interrupt
// controller. Assumes a 32-bit memory slave port with a decoded base.
package iira_pkg;

    // Memory offsets of the select register and data window in the base
    localparam logic [7:0] SELECT_OFFSET = 8'h00;
    localparam logic [7:0] WINDOW_OFFSET = 8'h10;
    // Fixed upper address digits and field of the base locator digits
    localparam logic [15:0] BASE_HIGH = 16'hFEC0;
    localparam int BASE_DIGIT_LSB = 8;
    localparam int BASE_DIGIT_MSB = 15;

    // Internal register indexes
    localparam logic [7:0] IDX_UNIT_ID = 8'h00;
    localparam logic [7:0] IDX_VERSION = 8'h01;
    localparam logic [7:0] IDX_ARB_PRIO = 8'h02;
    localparam logic [7:0] IDX_REDIR_FIRST = 8'h10;
    localparam logic [7:0] IDX_REDIR_LAST = 8'h2F;

    // Field positions
    localparam int ID_LSB = 24;
    localparam int ID_MSB = 27;
    localparam int MAXENT_LSB = 16;
    localparam int MAXENT_MSB = 23;
    localparam int VER_LSB = 0;
    localparam int VER_MSB = 7;
    localparam int SEL_MSB = 7;

    // Reset values and fixed fields
    localparam logic [3:0] ID_RESET = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Byte enables of a full doubleword store
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [7:0] MAX_ENTRY = 8'h0F;
    // Version code: arbitrary neutral value
    localparam logic [7:0] VERSION_CODE_DEFAULT = 8'h5A;

endpackage : iira_pkg

// >>> hw/iira_redir_store.sv
// Storage for the redirection entry halves reached through the window.
// Assumes single-cycle write strobes from the register decode.
module iira_redir_store #(
    parameter int ENTRIES = 16
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [5:0] half_idx_i,
    input wire logic [31:0] wr_data_i,
    output logic [31:0] rd_data_o
);

    // Two independent halves per entry
    logic [31:0] mem_q [0:2*ENTRIES-1];
    // Index bits that address the halves
    localparam int IDX_W = $clog2(2 * ENTRIES);

    ////////////////////////////////////////////////////////////////////////
    // Write port; contents undefined after reset, as for the table itself
    always_ff @(posedge mclk_i)
    begin
        // No store lands while reset is held
        if (wr_en_i && !sys_rst_i)
        begin
            mem_q[half_idx_i[IDX_W-1:0]] <= wr_data_i;
        end
    end

    // Read is combinational; the top registers it
    assign rd_data_o = mem_q[half_idx_i[IDX_W-1:0]];

endmodule : iira_redir_store

// >>> hw/iira_top.sv
// Indirect register access: select register, data window and the unit
// identifier, version and arbitration priority registers behind it.
// Assumes a simple memory slave port: one-cycle read/write strobes with a
// full 32-bit address, data returned one cycle after a read strobe.
// The redirection store is not cleared by reset; software loads it.

// Functional notes
// - Select and window at fixed offsets in base
// - Doubleword write loads the select register
// - Only select bits 7:0 address registers
// - Window accesses forward to selected register
// - Wide registers exposed as 32-bit halves
// - Index 00h holds resettable 4-bit identifier
// - Identifier write also loads arbitration priority
// - Index 02h read-only arbitration priority field
// - Index 01h returns maximum entry 0Fh
// - Version code in bits 7:0, maximum entry in bits 23:16, rest zero
// - Redirection halves occupy indexes 10h to 2Fh
module iira_top #(
    parameter logic [7:0] VERSION_CODE = iira_pkg::VERSION_CODE_DEFAULT,
    parameter int ENTRIES = 16
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] base_locator_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [3:0] mem_be_i,
    input wire logic [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_rvalid_o,
    output logic [3:0] unit_identifier_o,
    output logic [3:0] arbitration_priority_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [31:0] select_q;      // Whole select word; upper bits reserved
    logic [3:0] unit_id_q;      // Unit identifier field
    logic [3:0] arb_prio_q;     // Arbitration priority field
    logic [31:0] rdata_q;       // Registered read data
    logic rvalid_q;             // Read answer strobe

    // Decode helpers
    logic in_base; // Address lies in the located base
    logic hit_select; // Access aimed at the select register
    logic hit_window; // Access aimed at the data window
    logic full_word; // All four byte lanes enabled
    logic win_wr; // Full-word store through the window
    logic [7:0] index; // Internal register address
    logic redir_hit; // Index falls among the table halves
    logic redir_wr; // Store lands in a table half
    logic [31:0] redir_rdata; // Half addressed by the index
    logic [5:0] half_idx; // Half number, zero based

    ////////////////////////////////////////////////////////////////////////
    // Offset match in the low address byte; the base is matched apart
    function automatic logic hit_at(input logic [31:0] addr,
                                    input logic [7:0] offset);
        hit_at = (addr[iira_pkg::BASE_DIGIT_LSB-1:0] == offset);
    endfunction : hit_at

    // Place a 4-bit field at the identifier position of a zero word
    function automatic logic [31:0] id_word(input logic [3:0] f);
        id_word = iira_pkg::WORD_ZERO;
        id_word[iira_pkg::ID_MSB:iira_pkg::ID_LSB] = f;
    endfunction : id_word

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    // fixed upper digits, middle digits from the locator
    assign in_base = (mem_addr_i[31:16] == iira_pkg::BASE_HIGH) &&
        (mem_addr_i[iira_pkg::BASE_DIGIT_MSB:iira_pkg::BASE_DIGIT_LSB]
         == base_locator_i);
    // Both registers sit at fixed offsets inside that base
    assign hit_select = in_base &&
        hit_at(mem_addr_i, iira_pkg::SELECT_OFFSET);
    assign hit_window = in_base &&
        hit_at(mem_addr_i, iira_pkg::WINDOW_OFFSET);
    // Partial writes are dropped: software must store whole words
    assign full_word = (mem_be_i == iira_pkg::BE_ALL);
    // Every window store passes this one gate
    assign win_wr = mem_wr_i && hit_window && full_word;

    // low byte is index
    // The upper select bits are stored but play no part in the decode,
    // so a new select word takes effect on the very next access
    assign index = select_q[iira_pkg::SEL_MSB:0];

    assign redir_hit = (index >= iira_pkg::IDX_REDIR_FIRST) &&
                       (index <= iira_pkg::IDX_REDIR_LAST);
    // one 32-bit half per index
    // Cut on purpose: the range check bounds the difference to 0..31
    assign half_idx = 6'(index - iira_pkg::IDX_REDIR_FIRST);
    // Writes outside the table range never reach the store
    assign redir_wr = win_wr && redir_hit;

    ////////////////////////////////////////////////////////////////////////
    // Redirection halves; the store only holds the words, the table
    // fields themselves are interpreted elsewhere
    iira_redir_store #(
        .ENTRIES(ENTRIES)
    ) i_iira_redir_store (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(redir_wr),
        .half_idx_i(half_idx),
        .wr_data_i(mem_wdata_i),
        .rd_data_o(redir_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Select register; reserved upper bits are kept but never decoded
    // Partial stores are refused here too, as on the window
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            select_q <= iira_pkg::WORD_ZERO;
        end
        else if (mem_wr_i && hit_select && full_word)
        begin
            select_q <= mem_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identifier and arbitration priority
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            unit_id_q <= iira_pkg::ID_RESET;
            arb_prio_q <= iira_pkg::ID_RESET;
        end
        // identifier write path
        // Both fields load in one edge, so they can never be seen apart
        else if (win_wr && index == iira_pkg::IDX_UNIT_ID)
        begin
            unit_id_q <= mem_wdata_i[iira_pkg::ID_MSB:iira_pkg::ID_LSB];
            arb_prio_q <= mem_wdata_i[iira_pkg::ID_MSB:iira_pkg::ID_LSB];
        end
        // priority index 02h has no write path; others ignored
        // Stores to the version word or unmapped indexes change nothing
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answer, one cycle after the strobe
    // Every read strobe is answered, even one outside the base, so a
    // master never waits on a missed decode; the data stands until the
    // next read
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_q <= iira_pkg::WORD_ZERO;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= mem_rd_i;
            if (mem_rd_i)
            begin
                // Select reads back in full, reserved bits included
                if (hit_select)
                begin
                    rdata_q <= select_q;
                end
                else if (hit_window)
                begin
                    if (index == iira_pkg::IDX_UNIT_ID)
                    begin
                        rdata_q <= id_word(unit_id_q);
                    end
                    else if (index == iira_pkg::IDX_VERSION)
                    begin
                        // Cleared word first, then the two fixed fields
                        rdata_q <= iira_pkg::WORD_ZERO;
                        rdata_q[iira_pkg::MAXENT_MSB:iira_pkg::MAXENT_LSB]
                            <= iira_pkg::MAX_ENTRY;
                        rdata_q[iira_pkg::VER_MSB:iira_pkg::VER_LSB]
                            <= VERSION_CODE;
                    end
                    else if (index == iira_pkg::IDX_ARB_PRIO)
                    begin
                        rdata_q <= id_word(arb_prio_q);
                    end
                    else if (redir_hit)
                    begin
                        // The store reads from the current index
                        rdata_q <= redir_rdata;
                    end
                    else
                    begin
                        rdata_q <= iira_pkg::WORD_ZERO;
                    end
                end
                // Outside both registers: zero
                else
                begin
                    rdata_q <= iira_pkg::WORD_ZERO;
                end
            end
        end
    end

    // Outputs, all straight from flip-flops
    assign mem_rdata_o = rdata_q;
    assign mem_rvalid_o = rvalid_q;
    assign unit_identifier_o = unit_id_q;
    assign arbitration_priority_o = arb_prio_q;

endmodule : iira_top

// >>> testbench/iira_checker.sv
// Port checker for the indirect register access block.
// Assumes one clock domain with a synchronous active-high reset.
module iira_checker (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] base_locator_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [3:0] mem_be_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [31:0] mem_rdata_o,
    input wire logic mem_rvalid_o,
    input wire logic [3:0] unit_identifier_o,
    input wire logic [3:0] arbitration_priority_o
);
    // All properties sample on the bus clock and rest during reset
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Full-word stores to the select register and the data window
    logic sel_wr;
    logic win_wr;
    // Identifier field of the write data, for the load checks
    logic [3:0] wr_field;
    // Shadow of the select index, kept from the observed stores
    logic [7:0] sel_idx_q;
    assign sel_wr = mem_wr_i && mem_be_i == 4'hF
        && mem_addr_i == {16'hFEC0, base_locator_i, 8'h00};
    assign win_wr = mem_wr_i && mem_be_i == 4'hF
        && mem_addr_i == {16'hFEC0, base_locator_i, 8'h10};
    assign wr_field = mem_wdata_i[27:24];

    // Track which internal register the window points at
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            sel_idx_q <= 8'h00;
        end
        else if (sel_wr)
        begin
            sel_idx_q <= mem_wdata_i[7:0];
        end
    end

    a_read_answer: assert property (mem_rd_i |=> mem_rvalid_o)
        else $error("read strobe got no answer");
    a_no_stray: assert property (!mem_rd_i |=> !mem_rvalid_o)
        else $error("answer without a read");
    a_write_silent: assert property (mem_wr_i |=> !mem_rvalid_o)
        else $error("write produced an answer");
    a_prio_mirror: assert property (
        unit_identifier_o == arbitration_priority_o)
        else $error("priority differs from identifier");
    a_id_load: assert property (
        win_wr && sel_idx_q == 8'h00
        |=> unit_identifier_o == $past(wr_field))
        else $error("identifier did not take the written field");
    a_prio_load: assert property (
        win_wr && sel_idx_q == 8'h00
        |=> arbitration_priority_o == $past(wr_field))
        else $error("priority did not take the written field");
    a_id_cause: assert property (
        !(win_wr && sel_idx_q == 8'h00) |=> $stable(unit_identifier_o))
        else $error("identifier moved without window write");
    a_prio_cause: assert property (
        !(win_wr && sel_idx_q == 8'h00)
        |=> $stable(arbitration_priority_o))
        else $error("priority moved without window write");
    a_rdata_hold: assert property (
        !mem_rvalid_o && !$past(sys_rst_i) |-> $stable(mem_rdata_o))
        else $error("read data moved between answers");
    a_reset_state: assert property (
        $fell(sys_rst_i) |-> !mem_rvalid_o
        && mem_rdata_o == 32'h0 && unit_identifier_o == 4'h0)
        else $error("outputs not cleared by reset");
endmodule : iira_checker

bind iira_top iira_checker i_iira_checker (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .base_locator_i(base_locator_i),
    .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
    .mem_be_i(mem_be_i), .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(mem_rdata_o), .mem_rvalid_o(mem_rvalid_o),
    .unit_identifier_o(unit_identifier_o),
    .arbitration_priority_o(arbitration_priority_o));

// >>> testbench/iira_top_test.sv
// Self-checking bench for the indirect register access block.
// Assumes reads answer one cycle after a one-cycle strobe.
module iira_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] loc = 8'h12;
    logic [31:0] addr = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] be = 4'hF;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid;
    logic [3:0] uid;
    logic [3:0] prio;
    logic [31:0] got;
    int fail_count = 0;
    int n_tests = 0;
    localparam logic [7:0] VER = 8'h5A;
    // Whole version word: maximum entry 0Fh above the version code
    localparam logic [31:0] VER_WORD = {16'h000F, 8'h00, VER};
    // Unmapped indexes, edges of the holes included
    logic [7:0] unm [4] = '{8'h03, 8'h0F, 8'h30, 8'hFF};
    always #2.5 mclk_i = ~mclk_i;
    iira_top #(.VERSION_CODE(VER), .ENTRIES(16)) i_iira_top (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .base_locator_i(loc),
        .mem_addr_i(addr), .mem_wr_i(wr), .mem_rd_i(rd), .mem_be_i(be),
        .mem_wdata_i(wdata), .mem_rdata_o(rdata), .mem_rvalid_o(rvalid),
        .unit_identifier_o(uid), .arbitration_priority_o(prio));
    function automatic logic [31:0] at(input logic [7:0] off);
        return {16'hFEC0, loc, off};
    endfunction : at
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle strobe; the settle delay keeps output checks off the edge
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] b);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        #1;
    endtask : bus_wr
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        check("rvalid", {31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask : bus_rd
    task automatic acc_wr(input logic [7:0] idx, input logic [31:0] d);
        bus_wr(at(8'h00), {24'h0, idx}, 4'hF);
        bus_wr(at(8'h10), d, 4'hF);
    endtask : acc_wr
    task automatic acc_rd(input logic [7:0] idx, output logic [31:0] d);
        bus_wr(at(8'h00), {24'h0, idx}, 4'hF);
        bus_rd(at(8'h10), d);
    endtask : acc_rd
    // Watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        bus_rd(at(8'h00), got);
        check("select reset", got, 32'h0);
        acc_rd(8'h00, got);
        check("id reset", got, 32'h0);
        $display("Test reset done");
        acc_wr(8'h00, 32'h0300_0000);
        check("prio out", {28'h0, prio}, 32'h3);
        acc_rd(8'h00, got);
        check("id read", got, 32'h0300_0000);
        acc_wr(8'h02, 32'h0500_0000);
        acc_rd(8'h02, got);
        check("prio read", got, 32'h0300_0000);
        bus_wr(at(8'h00), 32'h0, 4'hF);
        bus_wr(at(8'h10), 32'h0900_0000, 4'h3);
        check("partial write", {28'h0, uid}, 32'h3);
        $display("Test identifier done");
        // Upper select bits are kept but must not alter the decode
        bus_wr(at(8'h00), 32'hABCD_0001, 4'hF);
        bus_rd(at(8'h00), got);
        check("select full", got, 32'hABCD_0001);
        bus_wr(at(8'h10), 32'hFFFF_FFFF, 4'hF);
        bus_rd(at(8'h10), got);
        check("version", got, VER_WORD);
        for (int i = 0; i < 32; i++)
            acc_wr(8'h10 + 8'(i), 32'hC0DE_0000 + 32'(i));
        for (int i = 0; i < 32; i++)
        begin
            acc_rd(8'h10 + 8'(i), got);
            check("redir", got, 32'hC0DE_0000 + 32'(i));
        end
        for (int k = 0; k < 4; k++)
        begin
            acc_wr(unm[k], 32'h1234_5678);
            acc_rd(unm[k], got);
            check("unmapped", got, 32'h0);
        end
        // Stores to unmapped indexes must leave the identifier alone
        check("unmapped side", {28'h0, uid}, 32'h3);
        $display("Test decode done");
        // Move the base; wait an edge so at() sees the new locator
        @(posedge mclk_i);
        loc <= 8'h34;
        @(posedge mclk_i);
        bus_wr(at(8'h00), 32'h0, 4'hF);
        bus_wr({16'hFEC0, 8'h12, 8'h10}, 32'h0700_0000, 4'hF);
        check("old base", {28'h0, uid}, 32'h3);
        acc_wr(8'h00, 32'h0600_0000);
        check("new base", {28'h0, uid}, 32'h6);
        check("new prio", {28'h0, prio}, 32'h6);
        bus_rd(32'h0000_1000, got);
        check("other addr", got, 32'h0);
        $display("Test base done");
        complete_run();
    end
endmodule : iira_top_test
